/* shared/rtc_alarm_params.svh */
`ifndef RTC_ALARM_PARAMS_SVH
`define RTC_ALARM_PARAMS_SVH

`define IDX_TIME_FIRST   8'h70
`define IDX_TIME_LAST    8'h78
`define IDX_ALARM_HOUR   8'h77
`define IDX_ALARM_DAY    8'h78
`define IDX_MODE         8'h79
`define IDX_STATUS       8'h7A

`define MODE_TICK_BIT    0
`define MODE_ALARM_BIT   1
`define MODE_PAUSE_BIT   5
`define MODE_RAM_BIT     6
`define MODE_TIME_BIT    7
`define STAT_TICK_BIT    0
`define STAT_ALARM_BIT   1
`define STAT_VALID_BIT   7

`define MODE_IMPL_MASK   8'hE3
`define REG_RESET        8'h00

`define CLK_FREQ_HZ      50000000
`define TICK_PERIOD_S    1
`define TICK_CYCLES      (`CLK_FREQ_HZ * `TICK_PERIOD_S)

`endif

/* shared/rtc_alarm_pkg.sv */
package rtc_alarm_pkg;

  typedef struct packed {
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hour;
    logic [11:0] day;
  } clock_time_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* test/rtc_alarm_periodic_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t %s", $time, m); end end
module rtc_alarm_periodic_control_tb;
  import rtc_alarm_pkg::*;
  // short tick keeps the run small; the tick and irq waits derive from it
  localparam int unsigned TICKS = 20;
  logic        mclk_i;
  logic        rstn_i;
  reg_req_t    req_i;
  clock_time_t now_i;
  logic [5:0]  alarm_sec_i;
  logic [5:0]  alarm_min_i;
  logic        standby_power_good_i;
  logic [7:0]  rdata_o;
  logic        clock_irq_out_o, time_regs_access_n_o, backup_ram_access_n_o;
  logic        time_regs_grant_o, pause_o, tick_o;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n_ticks = 0;
  int          t0 = 0;

  rtc_alarm_periodic_control #(.TICK_CYCLES(TICKS)) dut (
    .mclk_i               (mclk_i),
    .rstn_i               (rstn_i),
    .req_i                (req_i),
    .now_i                (now_i),
    .alarm_sec_i          (alarm_sec_i),
    .alarm_min_i          (alarm_min_i),
    .standby_power_good_i (standby_power_good_i),
    .rdata_o              (rdata_o),
    .clock_irq_out_o      (clock_irq_out_o),
    .time_regs_access_n_o (time_regs_access_n_o),
    .backup_ram_access_n_o(backup_ram_access_n_o),
    .time_regs_grant_o    (time_regs_grant_o),
    .pause_o              (pause_o),
    .tick_o               (tick_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_errors++;
      summarize();
    end
  end

  // tick_o is a one-cycle pulse, so it is counted where it has settled
  always @(negedge mclk_i)
  begin
    if (tick_o === 1'b1)
      n_ticks <= n_ticks + 1;
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge mclk_i);
    req_i = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
    @(negedge mclk_i);
    req_i = '0;
  endtask

  // read data stands one cycle, so it is sampled at the next falling edge
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    @(negedge mclk_i);
    req_i = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
    @(negedge mclk_i);
    req_i = '0;
    `CHK(rdata_o, e, "read data")
  endtask

  // bounded wait; irq is a level, so a late look still sees it
  task automatic wait_irq(input logic lvl, input int max);
    for (int i = 0; i < max && clock_irq_out_o !== lvl; i++)
      @(negedge mclk_i);
    `CHK(clock_irq_out_o, lvl, "irq level")
  endtask

  initial
  begin
    rstn_i = 1'b0;
    req_i = '0;
    now_i = '{sec: 6'h0A, min: 6'h14, hour: 5'h05, day: 12'h123};
    alarm_sec_i = 6'h0A;
    alarm_min_i = 6'h14;
    standby_power_good_i = 1'b1;
    repeat (20) @(negedge mclk_i);
    rstn_i = 1'b1;
    rd(8'h77, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    rd(8'h7A, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h77, 8'hFF);
    rd(8'h77, 8'h1F);
    wr(8'h78, 8'hE3);
    rd(8'h78, 8'h03);
    wr(8'h77, 8'h05);
    wr(8'h79, 8'hFF);
    @(negedge mclk_i);
    `CHK(time_regs_access_n_o, 1'b1, "time access")
    `CHK(backup_ram_access_n_o, 1'b1, "ram access")
    `CHK(pause_o, 1'b1, "pause")
    rd(8'h79, 8'hE3);
    wr(8'h77, 8'h00);
    rd(8'h77, 8'h00);
    `CHK(time_regs_grant_o, 1'b0, "grant while blocked")
    wr(8'h79, 8'h00);
    @(negedge mclk_i);
    `CHK(time_regs_access_n_o, 1'b0, "time access")
    `CHK(pause_o, 1'b0, "pause")
    rd(8'h77, 8'h05);
    `CHK(time_regs_grant_o, 1'b1, "grant while open")
    // a tick may slip in before pause lands, so start from a clean status
    wr(8'h7A, 8'h03);
    rd(8'h7A, 8'h00);
    t0 = n_ticks;
    repeat (3 * TICKS) @(negedge mclk_i);
    `CHK(n_ticks - t0, 3, "tick pulse count")
    `CHK(clock_irq_out_o, 1'b0, "irq while disabled")
    wr(8'h79, 8'h01);
    wait_irq(1'b1, 2 * TICKS + 5);
    rd(8'h7A, 8'h01);
    wr(8'h79, 8'h00);
    wr(8'h7A, 8'h01);
    rd(8'h7A, 8'h00);
    `CHK(clock_irq_out_o, 1'b0, "irq after clear")
    wr(8'h79, 8'h02);
    wait_irq(1'b1, 2 * TICKS + 5);
    rd(8'h7A, 8'h02);
    now_i.hour = 5'h06;
    wr(8'h7A, 8'h02);
    wait_irq(1'b0, 1);
    repeat (2 * TICKS + 5) @(negedge mclk_i);
    `CHK(clock_irq_out_o, 1'b0, "irq on hour mismatch")
    now_i = '{sec: 6'h0A, min: 6'h14, hour: 5'h05, day: 12'h3E3};
    wait_irq(1'b1, 2 * TICKS + 5);
    wr(8'h79, 8'h00);
    wr(8'h7A, 8'h02);
    wr(8'h7A, 8'h80);
    rd(8'h7A, 8'h80);
    wr(8'h79, 8'h20);
    repeat (2) @(negedge mclk_i);
    t0 = n_ticks;
    `CHK(time_regs_access_n_o, 1'b0, "time access while paused")
    `CHK(pause_o, 1'b1, "pause for setting")
    wr(8'h77, 8'h17);
    rd(8'h77, 8'h17);
    `CHK(time_regs_grant_o, 1'b1, "grant while paused")
    repeat (2 * TICKS) @(negedge mclk_i);
    `CHK(n_ticks - t0, 0, "tick while paused")
    wr(8'h79, 8'h00);
    standby_power_good_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    rd(8'h7A, 8'h00);
    wr(8'h7A, 8'h80);
    repeat (2) @(negedge mclk_i);
    rd(8'h7A, 8'h00);
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire

/* verilog/rtc_alarm_periodic_control.sv */
// Overview of operation
// (RL1) alarm hour: five bits, upper bits zero
// (RL2) alarm day matches low five day bits
// (RL3) unused bits ignore writes, read zero
// (RL4) all four alarm fields match raises alarm
// (RL5) mode bit 1 enables alarm interrupt
// (RL6) alarm and tick share one interrupt
// (RL7) status bit 1 pending; write one clears
// (RL8) mode bit 0 gives one-second interrupt
// (RL9) status bit 0 pending; write one clears
// (RL10) valid cleared by power loss, software sets
// (RL11) mode bit 7 blocks time registers
// (RL12) mode bit 6 blocks backup ram
// (RL13) mode bit 5 freezes time counters
// (RL14) software pauses, writes time, then resumes
// (RL15) software keeps clock out of doze
// (RL16) implemented bits reset to zero
// (RL17) hour counter counts zero to twenty-three
// (RL18) day count is twelve bits
// (RL19) software uses indexed register port
// (RL20) alarm checked once per second tick
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_params.svh"

module rtc_alarm_periodic_control
  import rtc_alarm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rstn_i,
  input  wire rtc_alarm_pkg::reg_req_t   req_i,
  input  wire rtc_alarm_pkg::clock_time_t now_i,
  input  wire logic [5:0]                alarm_sec_i,
  input  wire logic [5:0]                alarm_min_i,
  input  wire logic                      standby_power_good_i,
  output logic [7:0]                     rdata_o,
  output logic                           clock_irq_out_o,
  output logic                           time_regs_access_n_o,
  output logic                           backup_ram_access_n_o,
  output logic                           time_regs_grant_o,
  output logic                           pause_o,
  output logic                           tick_o
);
  import rtc_alarm_pkg::*;

  logic [4:0] alarm_hour_field;
  logic [4:0] alarm_day_field;
  logic [7:0] mode;
  logic       alarm_pend;
  logic       tick_pend;
  logic       valid;
  logic       pg_meta;
  logic       pg_sync;
  logic       sec_tick;
  logic [4:0] next_alarm_hour_field;
  logic [4:0] next_alarm_day_field;
  logic [7:0] next_mode;
  logic       next_alarm_pend;
  logic       next_tick_pend;
  logic       next_valid;
  logic [7:0] next_rdata;
  logic       alarm_hit;
  logic       time_ok;
  logic       wr_mode;
  logic       wr_stat;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction

  rtc_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .pause_i (mode[`MODE_PAUSE_BIT]),
    .tick_o  (sec_tick)
  );

  // time registers 70-78 reachable only while the gate bit is clear
  assign time_ok = !mode[`MODE_TIME_BIT]; // [RL11]
  assign wr_mode = req_i.wr && hit(req_i.index, `IDX_MODE);
  assign wr_stat = req_i.wr && hit(req_i.index, `IDX_STATUS);

  // compare only on the second tick so one match pends once
  assign alarm_hit = sec_tick && mode[`MODE_ALARM_BIT] // [RL4] [RL5] [RL20]
                     && now_i.sec == alarm_sec_i
                     && now_i.min == alarm_min_i
                     && now_i.hour == alarm_hour_field // [RL17]
                     && now_i.day[4:0] == alarm_day_field; // [RL2] [RL18]

  always_comb
  begin
    next_alarm_hour_field = alarm_hour_field;
    next_alarm_day_field  = alarm_day_field;
    next_mode             = mode;
    next_alarm_pend       = alarm_pend;
    next_tick_pend        = tick_pend;
    next_valid            = valid;
    if (req_i.wr && time_ok && hit(req_i.index, `IDX_ALARM_HOUR))
    begin
      next_alarm_hour_field = req_i.wdata[4:0]; // [RL1] [RL3]
    end
    if (req_i.wr && time_ok && hit(req_i.index, `IDX_ALARM_DAY))
    begin
      next_alarm_day_field = req_i.wdata[4:0]; // [RL2] [RL3]
    end
    if (wr_mode)
    begin
      next_mode = req_i.wdata & `MODE_IMPL_MASK; // [RL3]
    end
    if (wr_stat && req_i.wdata[`STAT_ALARM_BIT])
    begin
      next_alarm_pend = 1'b0; // [RL7]
    end
    if (wr_stat && req_i.wdata[`STAT_TICK_BIT])
    begin
      next_tick_pend = 1'b0; // [RL9]
    end
    if (wr_stat && req_i.wdata[`STAT_VALID_BIT])
    begin
      next_valid = 1'b1; // [RL10]
    end
    // new events win over a clear in the same cycle
    if (alarm_hit)
    begin
      next_alarm_pend = 1'b1; // [RL4]
    end
    if (sec_tick && mode[`MODE_TICK_BIT])
    begin
      next_tick_pend = 1'b1; // [RL8]
    end
    if (!pg_sync)
    begin
      next_valid = 1'b0; // [RL10]
    end
  end

  always_comb
  begin
    next_rdata = `REG_RESET;
    if (req_i.rd)
    begin
      case (req_i.index)
        `IDX_ALARM_HOUR:
        begin
          next_rdata = time_ok ? {3'h0, alarm_hour_field} : 8'h00; // [RL1] [RL11]
        end
        `IDX_ALARM_DAY:
        begin
          next_rdata = time_ok ? {3'h0, alarm_day_field} : 8'h00; // [RL3] [RL11]
        end
        `IDX_MODE:
        begin
          next_rdata = mode;
        end
        `IDX_STATUS:
        begin
          next_rdata = {valid, 5'h00, alarm_pend, tick_pend}; // [RL7] [RL9] [RL3]
        end
        default:
        begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      alarm_hour_field      <= 5'h00; // [RL16]
      alarm_day_field       <= 5'h00;
      mode                  <= `REG_RESET;
      alarm_pend            <= 1'b0;
      tick_pend             <= 1'b0;
      valid                 <= 1'b0;
      pg_meta               <= 1'b0;
      pg_sync               <= 1'b0;
      rdata_o               <= 8'h00;
      clock_irq_out_o       <= 1'b0;
      time_regs_access_n_o  <= 1'b0;
      backup_ram_access_n_o <= 1'b0;
      time_regs_grant_o     <= 1'b0;
      pause_o               <= 1'b0;
      tick_o                <= 1'b0;
    end
    else
    begin
      alarm_hour_field      <= next_alarm_hour_field;
      alarm_day_field       <= next_alarm_day_field;
      mode                  <= next_mode;
      alarm_pend            <= next_alarm_pend;
      tick_pend             <= next_tick_pend;
      valid                 <= next_valid;
      pg_meta               <= standby_power_good_i;
      pg_sync               <= pg_meta;
      rdata_o               <= next_rdata;
      clock_irq_out_o       <= next_alarm_pend || next_tick_pend; // [RL6]
      time_regs_access_n_o  <= next_mode[`MODE_TIME_BIT]; // [RL11]
      backup_ram_access_n_o <= next_mode[`MODE_RAM_BIT]; // [RL12]
      time_regs_grant_o     <= req_i.index >= `IDX_TIME_FIRST
                               && req_i.index <= `IDX_TIME_LAST
                               && (req_i.wr || req_i.rd) && time_ok; // [RL11]
      pause_o               <= next_mode[`MODE_PAUSE_BIT]; // [RL13]
      tick_o                <= sec_tick;
    end
  end

  chk_irq_follows_pend: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL6]
    ##1 (clock_irq_out_o == (alarm_pend || tick_pend)))
    else $error("interrupt does not follow pending flags");

  chk_alarm_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL7]
    (wr_stat && req_i.wdata[1] && !alarm_hit) |=> !alarm_pend)
    else $error("alarm pending not cleared");

  chk_tick_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL9]
    (wr_stat && req_i.wdata[0] && !(sec_tick && mode[0])) |=> !tick_pend)
    else $error("tick pending not cleared");

  chk_tick_set: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL8]
    (sec_tick && mode[0]) |=> tick_pend ##1 clock_irq_out_o)
    else $error("tick did not raise interrupt");

  chk_alarm_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL5]
    (!alarm_pend && !mode[1] && !wr_mode) |=> !alarm_pend)
    else $error("alarm pended while disabled");

  chk_valid_loss: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL10]
    (!standby_power_good_i ##1 !standby_power_good_i) |=> ##1 !valid)
    else $error("valid survived power loss");

  chk_mode_reserved: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL3]
    mode[4:2] == 3'h0)
    else $error("reserved mode bits set");

  chk_pause_holds: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL13]
    mode[5] |=> !sec_tick)
    else $error("tick while paused");

  chk_ram_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL12]
    wr_mode |=> (backup_ram_access_n_o == $past(req_i.wdata[`MODE_RAM_BIT])))
    else $error("ram gate does not follow mode write");

  chk_time_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL11]
    wr_mode |=> (time_regs_access_n_o == $past(req_i.wdata[`MODE_TIME_BIT])))
    else $error("time gate does not follow mode write");

  chk_pause_out: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL13]
    wr_mode |=> (pause_o == $past(req_i.wdata[`MODE_PAUSE_BIT])))
    else $error("pause does not follow mode write");

  chk_hour_write: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL1]
    (req_i.wr && !mode[`MODE_TIME_BIT] && req_i.index == `IDX_ALARM_HOUR)
    |=> (alarm_hour_field == $past(req_i.wdata[4:0])))
    else $error("alarm hour write lost");

  chk_hour_blocked: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL11]
    (req_i.wr && mode[`MODE_TIME_BIT] && req_i.index == `IDX_ALARM_HOUR)
    |=> $stable(alarm_hour_field))
    else $error("blocked alarm hour write landed");

  chk_day_blocked: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL11]
    (req_i.wr && mode[`MODE_TIME_BIT] && req_i.index == `IDX_ALARM_DAY)
    |=> $stable(alarm_day_field))
    else $error("blocked alarm day write landed");

  chk_time_block: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL11]
    (req_i.rd && mode[`MODE_TIME_BIT] && (req_i.index == `IDX_ALARM_HOUR
     || req_i.index == `IDX_ALARM_DAY)) |=> (rdata_o == 8'h00))
    else $error("blocked alarm register read not zero");

  chk_hour_reserved: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL1]
    (req_i.rd && req_i.index == `IDX_ALARM_HOUR) |=> (rdata_o[7:5] == 3'h0))
    else $error("alarm hour upper bits not zero");

  chk_day_reserved: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL3]
    (req_i.rd && req_i.index == `IDX_ALARM_DAY) |=> (rdata_o[7:5] == 3'h0))
    else $error("alarm day upper bits not zero");

  chk_status_reserved: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL3]
    (req_i.rd && req_i.index == `IDX_STATUS) |=> (rdata_o[6:2] == 5'h00))
    else $error("status reserved bits not zero");

  chk_valid_set: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL10]
    (wr_stat && req_i.wdata[`STAT_VALID_BIT] && pg_sync) |=> valid)
    else $error("valid not set by software");

  chk_alarm_set: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL4] [RL6]
    alarm_hit |=> (alarm_pend && clock_irq_out_o))
    else $error("alarm match did not raise interrupt");

  chk_alarm_on_tick: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL20]
    (!sec_tick && !alarm_pend) |=> !alarm_pend)
    else $error("alarm pended between ticks");

  chk_tick_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RL8]
    (!tick_pend && !mode[`MODE_TICK_BIT]) |=> !tick_pend)
    else $error("tick pended while disabled");

  cov_alarm: cover property (@(posedge mclk_i) disable iff (!rstn_i) alarm_hit);
  cov_tick: cover property (@(posedge mclk_i) disable iff (!rstn_i) sec_tick && mode[0]);
  cov_both: cover property (@(posedge mclk_i) disable iff (!rstn_i) alarm_pend && tick_pend);
  cov_pause_write: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_mode && req_i.wdata[`MODE_PAUSE_BIT]);
  cov_power_loss: cover property (@(posedge mclk_i) disable iff (!rstn_i) valid ##1 !valid);

endmodule
`default_nettype wire

/* verilog/rtc_tick_gen.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_params.svh"

module rtc_tick_gen #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic pause_i,
  output logic      tick_o
);

  logic [25:0] count;
  logic [25:0] next_count;
  logic        next_tick;

  // the divider holds its count while paused, so the second resumes where it stopped
  always_comb
  begin
    next_count = count;
    next_tick  = 1'b0;
    if (!pause_i)
    begin
      if (count == 26'(TICK_CYCLES - 1))
      begin
        next_count = 26'h0;
        next_tick  = 1'b1;
      end
      else
      begin
        next_count = count + 26'h1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      count  <= 26'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule
`default_nettype wire
